// ### rtl/cik_capacity_indicator_key_ctrl.v
// Operation
// - lamp count selectable three, four or five; thresholds follow the count.
// - five lamps discharging: 80/60/40/20/5 steps, lamp one flickers 1-5%, off 0%.
// - five lamps charging: all steady at 100%, else topmost active lamp flickers.
// - four lamps discharging: 75/50/25/5 steps, lamp one flickers 1-5%, off 0%.
// - four lamps charging: all steady at 100%, else topmost active lamp flickers.
// - three lamps discharging: 66/33/5 steps, lamp one flickers 1-5%, off 0%.
// - three lamps charging: all steady at 100%, else topmost active lamp flickers.
// - low battery: lamp one flickers five times, then power off.
// - fault: all lamps flicker five times, then power off.
// - segment discharging: steady capacity, flicker at 1 Hz below 5%.
// - segment low battery: 0% segment flickers five times, then power off.
// - segment charging: capacity segments flicker instead of steady.
// - segment fault: display flickers five times, then power off.
// - key events are short, long and double short presses.
// - short press enables type-A, light-load type-C and the display.
// - long press toggles flash lamp while the small-current feature is off.
// - with small-current feature, long press toggles that mode, not the lamp.
// - double press disables type-A, type-C and the display.
// - double press exits small-current mode; display marks the mode, which the code does on the lamps only, not in segment mode.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "cik_consts.vh"
module cik_capacity_indicator_key_ctrl #(
   parameter HALF_CYC     = `CIK_HALF_CYC,
   parameter DEBOUNCE_CYC = `CIK_DEBOUNCE_CYC,
   parameter LONG_CYC     = `CIK_LONG_CYC,
   parameter DBL_CYC      = `CIK_DBL_CYC
) (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [6:0]  capacity_pct,
   input  wire        charging,
   input  wire        low_battery,
   input  wire        fault,
   input  wire        key_pressed,
   input  wire        iface_select_strap,
   output reg         capacity_lamp_one,
   output reg         capacity_lamp_two,
   output reg         capacity_lamp_three,
   output reg         capacity_lamp_four,
   output reg         capacity_lamp_five,
   output reg  [4:0]  segment_on,
   output reg         segment_zero,
   output reg         shared_pins_serial,
   output reg         type_a_enable,
   output reg         type_c_enable,
   output reg         flash_lamp_driver,
   output reg         small_current_mode,
   output reg         power_off
);
   localparam M_NORM = 3'b001;
   localparam M_WARN = 3'b010;
   localparam M_OFF  = 3'b100;

   reg [31:0] ctrl_r;
   reg        aw_got_r;
   reg        w_got_r;
   reg [31:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0]  w_strb_r;
   reg [31:0] half_cnt_r;
   reg        flick_r;
   reg        flick_d_r;
   reg [2:0]  mode_r;
   reg        warn_fault_r;
   reg [2:0]  blink_cnt_r;
   reg        display_on_r;
   reg [4:0]  steady;
   reg [4:0]  blink;
   reg [4:0]  lamps_nxt;
   wire       short_press;
   wire       long_press;
   wire       double_press;
   wire [1:0] lamp_count = ctrl_r[`CIK_CTRL_COUNT_LSB+1:`CIK_CTRL_COUNT_LSB];
   wire       seg_mode   = ctrl_r[`CIK_CTRL_SEG_BIT];
   wire       scc_en     = ctrl_r[`CIK_CTRL_SCC_EN_BIT];
   wire       flick_rise = flick_r & ~flick_d_r;

   // lamps lit at or above each threshold; boundary values go to the higher range
   function [4:0] cik_bar;
      input [6:0] pct;
      input [1:0] cnt;
      begin
         cik_bar = 5'h00;
         case (cnt)
            `CIK_CNT_FIVE: begin
               if (pct >= 7'd80)      cik_bar = 5'h1f;
               else if (pct >= 7'd60) cik_bar = 5'h0f;
               else if (pct >= 7'd40) cik_bar = 5'h07;
               else if (pct >= 7'd20) cik_bar = 5'h03;
               else                   cik_bar = 5'h01;
            end
            `CIK_CNT_FOUR: begin
               if (pct >= 7'd75)      cik_bar = 5'h0f;
               else if (pct >= 7'd50) cik_bar = 5'h07;
               else if (pct >= 7'd25) cik_bar = 5'h03;
               else                   cik_bar = 5'h01;
            end
            default: begin
               if (pct >= 7'd66)      cik_bar = 5'h07;
               else if (pct >= 7'd33) cik_bar = 5'h03;
               else                   cik_bar = 5'h01;
            end
         endcase
      end
   endfunction

   function [4:0] cik_full;
      input [1:0] cnt;
      begin
         case (cnt)
            `CIK_CNT_FIVE: cik_full = 5'h1f;
            `CIK_CNT_FOUR: cik_full = 5'h0f;
            default:       cik_full = 5'h07;
         endcase
      end
   endfunction

   cik_key_decoder #(
      .DEBOUNCE_CYC (DEBOUNCE_CYC),
      .LONG_CYC     (LONG_CYC),
      .DBL_CYC      (DBL_CYC)
   ) u_key (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .key_pressed  (key_pressed),
      .short_press  (short_press),
      .long_press   (long_press),
      .double_press (double_press)
   );

   // axi4-lite slave: address and data taken in either order
   assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   always @(posedge sys_clk) begin
      if (rst) begin
         aw_got_r     <= 1'b0;
         w_got_r      <= 1'b0;
         aw_addr_r    <= 32'h0;
         w_data_r     <= 32'h0;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         ctrl_r       <= `CIK_CTRL_RST_VAL;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (aw_got_r && w_got_r) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_r[7:0] == `CIK_REG_CTRL && aw_addr_r[31:8] == 24'h0) begin
               s_axi_bresp <= 2'h0;
               if (w_strb_r[0])
                  ctrl_r[7:0] <= {4'h0, w_data_r[3:0]};
            end else begin
               s_axi_bresp <= 2'h2;
            end
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         s_axi_rdata  <= 32'h0;
         if (s_axi_araddr[31:8] != 24'h0) begin
            s_axi_rresp <= 2'h2;
         end else begin
            case (s_axi_araddr[7:0])
               `CIK_REG_CTRL:   s_axi_rdata <= {28'h0, ctrl_r[3:0]};
               `CIK_REG_CAP:    s_axi_rdata <= {25'h0, capacity_pct};
               `CIK_REG_STATUS: s_axi_rdata <= {24'h0, power_off, small_current_mode, flash_lamp_driver,
                                                display_on_r, iface_select_strap, fault, low_battery, charging};
               `CIK_REG_LAMPS:  s_axi_rdata <= {27'h0, capacity_lamp_five, capacity_lamp_four,
                                                capacity_lamp_three, capacity_lamp_two, capacity_lamp_one};
               default:         s_axi_rresp <= 2'h2;
            endcase
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // 1 hz flicker, equal halves
   always @(posedge sys_clk) begin
      if (rst) begin
         half_cnt_r <= 32'h0;
         flick_r    <= 1'b0;
         flick_d_r  <= 1'b0;
      end else begin
         flick_d_r <= flick_r;
         // a warning starts on a dark half, so no partial flash adds to the count
         if (mode_r == M_NORM && (fault || low_battery)) begin
            half_cnt_r <= 32'h0;
            flick_r    <= 1'b0;
         end else if (half_cnt_r >= HALF_CYC - 1) begin
            half_cnt_r <= 32'h0;
            flick_r    <= ~flick_r;
         end else begin
            half_cnt_r <= half_cnt_r + 32'h1;
         end
      end
   end

   // key actions and warning sequence
   always @(posedge sys_clk) begin
      if (rst) begin
         type_a_enable      <= 1'b0;
         type_c_enable      <= 1'b0;
         display_on_r       <= 1'b0;
         flash_lamp_driver  <= 1'b0;
         small_current_mode <= 1'b0;
         mode_r             <= M_NORM;
         warn_fault_r       <= 1'b0;
         blink_cnt_r        <= 3'h0;
         power_off          <= 1'b0;
         shared_pins_serial <= 1'b0;
      end else begin
         shared_pins_serial <= ~iface_select_strap;
         if (short_press) begin
            type_a_enable <= 1'b1;
            type_c_enable <= 1'b1;
            display_on_r  <= 1'b1;
         end
         if (long_press) begin
            if (scc_en)
               small_current_mode <= ~small_current_mode;
            else
               flash_lamp_driver <= ~flash_lamp_driver;
         end
         if (double_press) begin
            type_a_enable      <= 1'b0;
            type_c_enable      <= 1'b0;
            display_on_r       <= 1'b0;
            small_current_mode <= 1'b0;
         end
         case (mode_r)
            M_NORM: begin
               if (fault || low_battery) begin
                  mode_r       <= M_WARN;
                  warn_fault_r <= fault;
                  blink_cnt_r  <= 3'h0;
               end
            end
            M_WARN: begin
               if (flick_rise) begin
                  if (blink_cnt_r == `CIK_BLINKS - 1) begin
                     mode_r    <= M_OFF;
                     power_off <= 1'b1;
                  end else begin
                     blink_cnt_r <= blink_cnt_r + 3'h1;
                  end
               end
            end
            M_OFF: begin
               power_off         <= 1'b1;
               type_a_enable     <= 1'b0;
               type_c_enable     <= 1'b0;
               flash_lamp_driver <= 1'b0;
            end
            default: mode_r <= M_NORM;
         endcase
      end
   end

   // capacity pattern
   always @* begin
      steady = 5'h00;
      blink  = 5'h00;
      if (charging) begin
         if (capacity_pct >= 7'd100) begin
            steady = cik_full(lamp_count);
         end else begin
            blink  = cik_bar(capacity_pct, lamp_count) & ~(cik_bar(capacity_pct, lamp_count) >> 1);
            steady = cik_bar(capacity_pct, lamp_count) >> 1;
         end
      end else if (capacity_pct >= 7'd5) begin
         steady = cik_bar(capacity_pct, lamp_count);
      end else if (capacity_pct >= 7'd1) begin
         blink = 5'h01;
      end
      lamps_nxt = steady | (flick_r ? blink : 5'h00);
      if (small_current_mode)
         lamps_nxt = cik_full(lamp_count) & {5{flick_r}};
      if (mode_r == M_WARN) begin
         if (warn_fault_r)
            lamps_nxt = cik_full(lamp_count) & {5{flick_r}};
         else
            lamps_nxt = {4'h0, flick_r};
      end
      if (mode_r == M_OFF || !display_on_r || seg_mode || ~iface_select_strap)
         lamps_nxt = 5'h00;
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         capacity_lamp_one   <= 1'b0;
         capacity_lamp_two   <= 1'b0;
         capacity_lamp_three <= 1'b0;
         capacity_lamp_four  <= 1'b0;
         capacity_lamp_five  <= 1'b0;
         segment_on          <= 5'h00;
         segment_zero        <= 1'b0;
      end else begin
         {capacity_lamp_five, capacity_lamp_four, capacity_lamp_three,
          capacity_lamp_two, capacity_lamp_one} <= lamps_nxt;
         segment_on   <= 5'h00;
         segment_zero <= 1'b0;
         if (seg_mode && iface_select_strap && display_on_r && mode_r != M_OFF) begin
            if (mode_r == M_WARN) begin
               if (warn_fault_r)
                  segment_on <= {5{flick_r}};
               else
                  segment_zero <= flick_r;
            end else if (charging) begin
               segment_on <= {5{flick_r}};
            end else if (capacity_pct < 7'd5) begin
               segment_on <= {5{flick_r}};
            end else begin
               segment_on <= 5'h1f;
            end
         end
      end
   end
endmodule

// ### rtl/cik_consts.vh
`ifndef CIK_CONSTS_VH
`define CIK_CONSTS_VH
// register byte offsets
`define CIK_REG_CTRL        8'h00
`define CIK_REG_CAP         8'h04
`define CIK_REG_STATUS      8'h08
`define CIK_REG_LAMPS       8'h0c
// control field positions
`define CIK_CTRL_COUNT_LSB  0
`define CIK_CTRL_SEG_BIT    2
`define CIK_CTRL_SCC_EN_BIT 3
`define CIK_CTRL_RST_VAL    32'h0000_0002
// status field positions
`define CIK_ST_CHG_BIT      0
`define CIK_ST_LOWBAT_BIT   1
`define CIK_ST_FAULT_BIT    2
`define CIK_ST_STRAP_BIT    3
// lamp count codes
`define CIK_CNT_THREE       2'h0
`define CIK_CNT_FOUR        2'h1
`define CIK_CNT_FIVE        2'h2
// timing
`define CIK_CLK_HZ          100000000
`define CIK_FLICK_HZ        1
`define CIK_HALF_CYC        (`CIK_CLK_HZ / (2 * `CIK_FLICK_HZ))
`define CIK_DEBOUNCE_MS     20
`define CIK_DEBOUNCE_CYC    (`CIK_DEBOUNCE_MS * (`CIK_CLK_HZ / 1000))
`define CIK_LONG_MS         2000
`define CIK_LONG_CYC        (`CIK_LONG_MS * (`CIK_CLK_HZ / 1000))
`define CIK_DBL_MS          400
`define CIK_DBL_CYC         (`CIK_DBL_MS * (`CIK_CLK_HZ / 1000))
`define CIK_BLINKS          5
`endif

// ### rtl/cik_key_decoder.v
`timescale 1ns/100ps
`include "cik_consts.vh"
module cik_key_decoder #(
   parameter DEBOUNCE_CYC = `CIK_DEBOUNCE_CYC,
   parameter LONG_CYC     = `CIK_LONG_CYC,
   parameter DBL_CYC      = `CIK_DBL_CYC
) (
   input  wire sys_clk,
   input  wire rst,
   input  wire key_pressed,
   output reg  short_press,
   output reg  long_press,
   output reg  double_press
);
   localparam S_IDLE = 4'b0001;
   localparam S_DOWN = 4'b0010;
   localparam S_WAIT = 4'b0100;
   localparam S_HELD = 4'b1000;
   reg [31:0] deb_cnt_r;
   reg        key_r;
   reg [31:0] tmr_r;
   reg [3:0]  state_r;
   reg        second_r;
   // debounce filter
   always @(posedge sys_clk) begin
      if (rst) begin
         deb_cnt_r <= 32'h0;
         key_r     <= 1'b0;
      end else if (key_pressed == key_r) begin
         deb_cnt_r <= 32'h0;
      end else if (deb_cnt_r >= DEBOUNCE_CYC - 1) begin
         deb_cnt_r <= 32'h0;
         key_r     <= key_pressed;
      end else begin
         deb_cnt_r <= deb_cnt_r + 32'h1;
      end
   end
   // press classifier
   always @(posedge sys_clk) begin
      if (rst) begin
         state_r      <= S_IDLE;
         tmr_r        <= 32'h0;
         second_r     <= 1'b0;
         short_press  <= 1'b0;
         long_press   <= 1'b0;
         double_press <= 1'b0;
      end else begin
         short_press  <= 1'b0;
         long_press   <= 1'b0;
         double_press <= 1'b0;
         case (state_r)
            S_IDLE: begin
               tmr_r    <= 32'h0;
               second_r <= 1'b0;
               if (key_r)
                  state_r <= S_DOWN;
            end
            S_DOWN: begin
               tmr_r <= tmr_r + 32'h1;
               if (!key_r) begin
                  tmr_r <= 32'h0;
                  if (second_r) begin
                     double_press <= 1'b1;
                     state_r      <= S_IDLE;
                  end else begin
                     state_r <= S_WAIT;
                  end
               end else if (tmr_r >= LONG_CYC - 1 && !second_r) begin
                  long_press <= 1'b1;
                  state_r    <= S_HELD;
               end
            end
            S_WAIT: begin
               tmr_r <= tmr_r + 32'h1;
               if (key_r) begin
                  second_r <= 1'b1;
                  tmr_r    <= 32'h0;
                  state_r  <= S_DOWN;
               end else if (tmr_r >= DBL_CYC - 1) begin
                  short_press <= 1'b1;
                  state_r     <= S_IDLE;
               end
            end
            S_HELD: begin
               if (!key_r)
                  state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule

// ### bench/cik_key_model.sv
`timescale 1ns/100ps
module cik_key_model (
   input  wire  sys_clk,
   output logic key_pressed,
   output logic iface_select_strap
);
   initial begin
      key_pressed = 1'b0;
      iface_select_strap = 1'b1;
   end
   // a released key falls back to its pull-down level
   task press(input int hold);
      @(posedge sys_clk);
      key_pressed <= 1'b1;
      repeat (hold) @(posedge sys_clk);
      key_pressed <= 1'b0;
   endtask
   // low hands the shared pins to the serial port
   task strap(input logic v);
      @(posedge sys_clk);
      iface_select_strap <= v;
   endtask
endmodule

// ### bench/cik_ctrl_asserts.sv
`timescale 1ns/100ps
module cik_ctrl_asserts (
   input wire       sys_clk,
   input wire       rst,
   input wire       key_pressed,
   input wire       iface_select_strap,
   input wire       low_battery,
   input wire       fault,
   input wire       capacity_lamp_one,
   input wire       capacity_lamp_two,
   input wire       capacity_lamp_three,
   input wire       capacity_lamp_four,
   input wire       capacity_lamp_five,
   input wire [4:0] segment_on,
   input wire       segment_zero,
   input wire       shared_pins_serial,
   input wire       type_a_enable,
   input wire       type_c_enable,
   input wire       flash_lamp_driver,
   input wire       small_current_mode,
   input wire       power_off
);
   localparam int OFF_MAX = 400;
   wire [4:0] lamps   = {capacity_lamp_five, capacity_lamp_four, capacity_lamp_three,
                         capacity_lamp_two, capacity_lamp_one};
   wire       any_lit = (|lamps) | (|segment_on) | segment_zero;
   reg        lit_r;
   reg  [3:0] blink_r;
   // counts flicker rises since the warning began
   always @(posedge sys_clk) begin
      lit_r <= any_lit;
      if (rst || $rose(low_battery | fault))
         blink_r <= 4'h0;
      else if (any_lit && !lit_r && blink_r != 4'hf)
         blink_r <= blink_r + 4'h1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence warn_rise;
      $rose(low_battery | fault) ##1 (low_battery | fault);
   endsequence
   sequence off_arrives;
      ##[1:OFF_MAX] power_off;
   endsequence
   a_warn_off_bound: assert property (warn_rise |-> off_arrives) else $error("no power off after warning");
   a_blink_count: assert property ($rose(power_off) |->
      blink_r == 4'h5 || (blink_r == 4'h4 && any_lit && !lit_r)) else $error("flicker count wrong");
   a_power_hold: assert property (power_off |=> power_off) else $error("power off released");
   a_strap_serial: assert property (!rst ##1 1'b1 |-> shared_pins_serial == !$past(iface_select_strap))
      else $error("shared pin owner wrong");
   a_blank_serial: assert property (!iface_select_strap [*3] |-> lamps == 5'h0 && segment_on == 5'h0)
      else $error("display lit in serial mode");
   a_ports_paired: assert property (type_a_enable == type_c_enable) else $error("outputs split");
   a_short_released: assert property ($rose(type_a_enable) |-> !$past(key_pressed) && !$past(key_pressed, 4))
      else $error("short press while key held");
   a_flash_scc_apart: assert property ($changed(flash_lamp_driver) && !power_off |-> $stable(small_current_mode))
      else $error("flash and small mode moved together");
endmodule
bind cik_capacity_indicator_key_ctrl cik_ctrl_asserts u_chk (.sys_clk, .rst, .key_pressed, .iface_select_strap,
   .low_battery, .fault, .capacity_lamp_one, .capacity_lamp_two, .capacity_lamp_three, .capacity_lamp_four,
   .capacity_lamp_five, .segment_on, .segment_zero, .shared_pins_serial, .type_a_enable, .type_c_enable,
   .flash_lamp_driver, .small_current_mode, .power_off);

// ### bench/test_capacity_indicator_key_ctrl.sv
`timescale 1ns/100ps
module test_capacity_indicator_key_ctrl;
   logic        sys_clk;
   logic        rst;
   logic [31:0] awaddr, wdata, araddr, rd;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [6:0]  pct;
   logic        chg, lowb, flt;
   logic [1:0]  rr, rb;
   logic [3:0]  ws;
   logic [4:0]  lo, la;
   logic        so, sa;
   wire         key, strap, awready, wready, bvalid, arready, rvalid, sps, ta, tc, fl, scc, pwr;
   wire         l1, l2, l3, l4, l5, sz;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [4:0]  seg;
   wire  [4:0]  lamps = {l5, l4, l3, l2, l1};
   int          n_errors = 0;
   int          check_count = 0;
   int          cp[8] = '{0, 1, 4, 5, 0, 0, 99, 100};

   cik_key_model km (.sys_clk(sys_clk), .key_pressed(key), .iface_select_strap(strap));
   cik_capacity_indicator_key_ctrl #(.HALF_CYC(10), .DEBOUNCE_CYC(2), .LONG_CYC(50), .DBL_CYC(20)) dut (
      .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .capacity_pct(pct), .charging(chg), .low_battery(lowb),
      .fault(flt), .key_pressed(key), .iface_select_strap(strap), .capacity_lamp_one(l1),
      .capacity_lamp_two(l2), .capacity_lamp_three(l3), .capacity_lamp_four(l4), .capacity_lamp_five(l5),
      .segment_on(seg), .segment_zero(sz), .shared_pins_serial(sps), .type_a_enable(ta), .type_c_enable(tc),
      .flash_lamp_driver(fl), .small_current_mode(scc), .power_off(pwr));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task complete_run;
      if (n_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task do_reset;
      @(posedge sys_clk);
      rst <= 1'b1;
      cyc(6);
      rst <= 1'b0;
   endtask

   task axw(input logic [31:0] a, input logic [31:0] d);
      logic tka, tkw, tkb;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge sys_clk);
         tka = awvalid & awready;
         tkw = wvalid & wready;
         tkb = bvalid;
         rb = bresp;
         @(posedge sys_clk);
         if (tka) awvalid <= 1'b0;
         if (tkw) wvalid <= 1'b0;
      end while (!tkb);
      bready <= 1'b0;
   endtask

   task axr(input logic [31:0] a);
      logic tka, tkr;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge sys_clk);
         tka = arvalid & arready;
         tkr = rvalid;
         rd = rdata;
         rr = rresp;
         @(posedge sys_clk);
         if (tka) arvalid <= 1'b0;
      end while (!tkr);
      rready <= 1'b0;
   endtask

   // spans more than one whole flicker period
   task obs;
      lo = 5'h0;
      la = 5'h1f;
      so = 1'b0;
      sa = 1'b1;
      repeat (24) begin
         @(negedge sys_clk);
         lo = lo | lamps;
         la = la & lamps;
         so = so | (|seg) | sz;
         sa = sa & ((|seg) | sz);
      end
   endtask

   task set_in(input int p, input logic c);
      @(posedge sys_clk);
      pct <= p[6:0];
      chg <= c;
      cyc(4);
   endtask

   // returns {lit at some time, lit all the time} per lamp
   function automatic logic [9:0] exp_lamp(input int n, input int p, input logic c);
      int lv;
      logic [4:0] st, fk;
      lv = 1;
      st = 5'h0;
      fk = 5'h0;
      for (int j = 1; j < n; j++) if (p >= 100 * j / n) lv++;
      for (int j = 0; j < n; j++) begin
         if (c) begin
            if (p == 100 || j < lv - 1) st[j] = 1'b1;
            else if (j == lv - 1) fk[j] = 1'b1;
         end else if (p >= 5) st[j] = (j < lv);
         else if (p >= 1) fk[j] = (j == 0);
      end
      return {st | fk, st};
   endfunction

   initial begin
      cyc(60000);
      n_errors++;
      complete_run;
   end

   initial begin
      int n, p, nb;
      logic cur, prv;
      rst = 1'b1;
      ws = 4'hf;
      {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready, pct, chg, lowb, flt} = '0;
      void'($urandom(32'h436c));
      do_reset;
      chk("idle", 32'h0, {ta, tc, fl, scc, pwr, lamps});
      axr(32'h0);
      chk("ctrl", 32'h2, rd);
      axr(32'h10);
      chk("unmapped", 32'h2, rr);
      ws <= 4'($urandom_range(7)) << 1;
      axw(32'h4, 32'h1);
      chk("wresp", 32'h2, rb);
      axw(32'h0, 32'h1);
      chk("wresp", 32'h0, rb);
      axr(32'h0);
      chk("strobe", 32'h2, rd);
      ws <= 4'hf;
      km.press(5);
      cyc(30);
      chk("short", 32'h3, {ta, tc});
      for (int cn = 0; cn < 3; cn++) begin
         n = cn + 3;
         cp[4] = 100 / n;
         cp[5] = 100 * (n - 1) / n;
         axw(32'h0, cn);
         axr(32'h0);
         chk("ctrl", cn, rd[3:0]);
         for (int c = 0; c < 2; c++) for (int k = 0; k < 10; k++) begin
            p = (k < 8) ? cp[k] : $urandom_range(100);
            set_in(p, c[0]);
            axr(32'h4);
            chk("cap", p, rd);
            obs;
            chk("lamps", exp_lamp(n, p, c[0]), {lo, la});
         end
      end
      axw(32'h0, 32'h6);
      for (int k = 0; k < 3; k++) begin
         set_in(k == 1 ? 3 : 50, k == 2);
         obs;
         chk("segments", k == 0 ? 32'h3 : 32'h2, {so, sa});
      end
      axw(32'h0, 32'h2);
      km.press(60);
      cyc(30);
      chk("flash", 32'h1, {scc, fl});
      axw(32'h0, 32'ha);
      km.press(60);
      cyc(30);
      chk("small mode", 32'h3, {scc, fl});
      obs;
      chk("small show", 32'h3e0, {lo, la});
      km.strap(1'b0);
      cyc(4);
      chk("serial", 32'h1, sps);
      obs;
      chk("serial dark", 32'h0, lo);
      km.strap(1'b1);
      km.press(5);
      cyc(5);
      km.press(5);
      cyc(30);
      chk("double", 32'h0, {ta, tc, scc});
      obs;
      chk("dark", 32'h0, lo);
      for (int w = 0; w < 4; w++) begin
         do_reset;
         if (w > 1) axw(32'h0, 32'h6);
         km.press(5);
         cyc(30);
         set_in(50, 1'b0);
         lowb <= !w[0];
         flt <= w[0];
         nb = 0;
         prv = 1'b1;
         for (int i = 0; i < 400 && !pwr; i++) begin
            @(negedge sys_clk);
            cur = (w == 0) ? l1 : (w == 1) ? l5 : (w == 2) ? sz : seg[4];
            if (cur && !prv) nb++;
            prv = cur;
         end
         chk("blinks", 32'h5, nb);
         chk("off", 32'h1, pwr);
         @(posedge sys_clk);
         lowb <= 1'b0;
         flt <= 1'b0;
      end
      complete_run;
   end
endmodule
